// ### rtl/asc_host.sv
// Host controller driving a 32K x 8 asynchronous static memory
`timescale 1ns/1ps
// How it works
// - A write happens while write strobe and chip select are both low together.
// - The host sets the address before a write and holds it through the whole overlap.
// - Data is stored at the first rising strobe, so the host keeps data valid around it.
// - A read needs select low, write high and output enable low.
// - The host never drives the data pins while the memory drives read data.
module asc_host
    import asc_pkg::*;
(
    input  wire logic                      ref_clk_i,  // 20 MHz clock
    input  wire logic                      rst_b_i,    // Async reset, active low
    input  wire asc_pkg::asc_req_t         req_i,      // Request: write flag, address, data
    input  wire logic                      req_vld_i,  // Request valid
    output logic                           req_rdy_o,  // Ready for a request
    output logic [asc_pkg::ASC_DATA_W-1:0] rdata_o,    // Read data
    output logic                           rdata_vld_o,// Read data valid pulse
    output logic                           wr_done_o,  // Write finished pulse
    output asc_pkg::asc_pins_t             pins_o,     // Select, strobes, address
    output logic [asc_pkg::ASC_DATA_W-1:0] dq_o,       // Data to memory
    output logic                           dq_oe_o,    // Host drives data pins
    input  wire logic [asc_pkg::ASC_DATA_W-1:0] dq_i   // Data from memory
);
    import asc_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE, ST_WSET, ST_WPULSE, ST_WREL, ST_READ, ST_RREL, ST_TURN
    } asc_state_t;

    // Elaboration checks: every phase count must be non-zero and fit the wait counter
    if (ASC_RD_CYC < 1 || ASC_RD_CYC >= (1 << ASC_CNT_W)) begin : g_bad_rd
        $error("asc_host: read phase count does not fit the wait counter");
    end
    if (ASC_WR_CYC < 1 || ASC_WR_CYC >= (1 << ASC_CNT_W)) begin : g_bad_wr
        $error("asc_host: write phase count does not fit the wait counter");
    end
    if (ASC_TRN_CYC < 1 || ASC_TRN_CYC >= (1 << ASC_CNT_W)) begin : g_bad_trn
        $error("asc_host: turnaround count does not fit the wait counter");
    end
    if (ASC_WORDS != (1 << ASC_ADDR_W)) begin : g_bad_map
        $error("asc_host: word count does not match the address width");
    end

    asc_state_t              st_r;
    asc_state_t              st_nxt;
    asc_pins_t               pins_r;
    asc_pins_t               pins_nxt;
    logic [ASC_DATA_W-1:0]   dq_r;
    logic [ASC_DATA_W-1:0]   dq_nxt;
    logic                    dqoe_r;
    logic                    dqoe_nxt;
    logic [ASC_DATA_W-1:0]   rd_r;
    logic [ASC_DATA_W-1:0]   rd_nxt;
    logic                    rv_r;
    logic                    rv_nxt;
    logic                    wd_r;
    logic                    wd_nxt;
    logic                    rdy_r;
    logic                    rdy_nxt;
    logic                    ld;
    logic [ASC_CNT_W-1:0]    ld_cnt;
    logic                    done;

    // One shared counter times the write strobe, read and turnaround phases
    asc_wait #(.CW(ASC_CNT_W)) u_wait (
        .ref_clk_i (ref_clk_i),
        .rst_b_i   (rst_b_i),
        .load_i    (ld),
        .count_i   (ld_cnt),
        .done_o    (done)
    );

    // Control group: sequence, memory pins and ready
    always_comb begin
        st_nxt   = st_r;
        pins_nxt = pins_r;
        rdy_nxt  = rdy_r;
        ld       = 1'b0;
        ld_cnt   = '0;
        case (st_r)
            ST_IDLE: begin
                if (req_vld_i && rdy_r) begin
                    rdy_nxt       = 1'b0;
                    pins_nxt.addr = req_i.addr;
                    if (req_i.wr) begin
                        // Output enable stays high so the memory never drives during a write
                        pins_nxt.oe_n = 1'b1;
                        pins_nxt.sel_n = 1'b1;
                        st_nxt   = ST_WSET;
                    end else begin
                        pins_nxt.sel_n = 1'b0;
                        pins_nxt.wr_n  = 1'b1;
                        pins_nxt.oe_n  = 1'b0;
                        ld       = 1'b1;
                        ld_cnt   = ASC_CNT_W'(ASC_RD_CYC);
                        st_nxt   = ST_READ;
                    end
                end
            end
            ST_WSET: begin
                // Strobe and select fall together once address is stable
                pins_nxt.sel_n = 1'b0;
                pins_nxt.wr_n  = 1'b0;
                ld       = 1'b1;
                ld_cnt   = ASC_CNT_W'(ASC_WR_CYC);
                st_nxt   = ST_WPULSE;
            end
            ST_WPULSE: begin
                if (done) begin
                    pins_nxt.wr_n = 1'b1;
                    st_nxt = ST_WREL;
                end
            end
            ST_WREL: begin
                // Address held one cycle past the rising strobe
                pins_nxt.sel_n = 1'b1;
                rdy_nxt  = 1'b1;
                st_nxt   = ST_IDLE;
            end
            ST_READ: begin
                if (done) begin
                    pins_nxt.oe_n  = 1'b1;
                    pins_nxt.sel_n = 1'b1;
                    ld     = 1'b1;
                    ld_cnt = ASC_CNT_W'(ASC_TRN_CYC);
                    st_nxt = ST_TURN;
                end
            end
            ST_TURN: begin
                // Let the memory release the bus before the next write drives it
                if (done) begin
                    rdy_nxt = 1'b1;
                    st_nxt  = ST_IDLE;
                end
            end
            default: begin
                st_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_r   <= ST_IDLE;
            pins_r <= '{sel_n: 1'b1, wr_n: 1'b1, oe_n: 1'b1, addr: '0};
            rdy_r  <= 1'b1;
        end else begin
            st_r   <= st_nxt;
            pins_r <= pins_nxt;
            rdy_r  <= rdy_nxt;
        end
    end

    // Data drive group: the host owns the data pins only from a write's take to its release
    always_comb begin
        dq_nxt   = dq_r;
        dqoe_nxt = dqoe_r;
        if (st_r == ST_IDLE && req_vld_i && rdy_r) begin
            dqoe_nxt = req_i.wr;
            if (req_i.wr) begin
                dq_nxt = req_i.wdata;
            end
        end else if (st_r == ST_WREL) begin
            // Data held one cycle past the rising write strobe
            dqoe_nxt = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dq_r   <= '0;
            dqoe_r <= 1'b0;
        end else begin
            dq_r   <= dq_nxt;
            dqoe_r <= dqoe_nxt;
        end
    end

    // Response group: read capture and the one-cycle completion pulses
    always_comb begin
        rd_nxt = rd_r;
        rv_nxt = 1'b0;
        wd_nxt = 1'b0;
        if (st_r == ST_READ && done) begin
            // Sampled while select and output enable are still low
            rd_nxt = dq_i;
            rv_nxt = 1'b1;
        end
        if (st_r == ST_WREL) begin
            wd_nxt = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rd_r <= '0;
            rv_r <= 1'b0;
            wd_r <= 1'b0;
        end else begin
            rd_r <= rd_nxt;
            rv_r <= rv_nxt;
            wd_r <= wd_nxt;
        end
    end

    assign pins_o      = pins_r;
    assign dq_o        = dq_r;
    assign dq_oe_o     = dqoe_r;
    assign rdata_o     = rd_r;
    assign rdata_vld_o = rv_r;
    assign wr_done_o   = wd_r;
    assign req_rdy_o   = rdy_r;
endmodule : asc_host

// ### rtl/asc_pkg.sv
// Package for the static memory host controller: widths, timing counts and carrier types
package asc_pkg;
    localparam int ASC_ADDR_W    = 15;
    localparam int ASC_DATA_W    = 8;
    localparam int ASC_WORDS     = 32768;
    localparam int ASC_CLK_NS    = 50;
    // Minimum times in ns held by the host around each access
    localparam int ASC_T_READ_NS  = 70;
    localparam int ASC_T_WPULSE_NS = 55;
    localparam int ASC_T_SETUP_NS = 65;
    localparam int ASC_T_TURN_NS  = 25;
    localparam int ASC_RD_CYC  = (ASC_T_READ_NS + ASC_CLK_NS - 1) / ASC_CLK_NS;
    localparam int ASC_WR_CYC  = (ASC_T_SETUP_NS + ASC_CLK_NS - 1) / ASC_CLK_NS;
    localparam int ASC_TRN_CYC = (ASC_T_TURN_NS + ASC_CLK_NS - 1) / ASC_CLK_NS;
    localparam int ASC_CNT_W   = 4;

    typedef struct packed {
        logic                  wr;
        logic [ASC_ADDR_W-1:0] addr;
        logic [ASC_DATA_W-1:0] wdata;
    } asc_req_t;

    typedef struct packed {
        logic                  sel_n;
        logic                  wr_n;
        logic                  oe_n;
        logic [ASC_ADDR_W-1:0] addr;
    } asc_pins_t;
endpackage : asc_pkg

// ### rtl/asc_wait.sv
// Down-counter that times the write strobe, read and turnaround phases
`timescale 1ns/1ps
module asc_wait #(
    parameter int CW = 4
) (
    input  wire logic          ref_clk_i,   // Clock
    input  wire logic          rst_b_i,     // Async reset, active low
    input  wire logic          load_i,      // Load a new count
    input  wire logic [CW-1:0] count_i,     // Cycles to wait
    output logic               done_o       // Count at zero
);
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        if (load_i) begin
            cnt_nxt = count_i;
        end else if (cnt_r != '0) begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign done_o = (cnt_r == '0);
endmodule : asc_wait

// ### bench/asc_host_checker.sv
// Pin-level checks of the static memory host controller
`timescale 1ns/1ps
module asc_host_checker
    import asc_pkg::*;
(
    input wire logic                      ref_clk_i,   // Clock
    input wire logic                      rst_b_i,     // Reset, active low
    input wire asc_pkg::asc_req_t         req_i,       // Request
    input wire logic                      req_vld_i,   // Request valid
    input wire logic                      req_rdy_o,   // Ready
    input wire logic [ASC_DATA_W-1:0]     rdata_o,     // Read data
    input wire logic                      rdata_vld_o, // Read pulse
    input wire logic                      wr_done_o,   // Write pulse
    input wire asc_pkg::asc_pins_t        pins_o,      // Memory controls
    input wire logic [ASC_DATA_W-1:0]     dq_o,        // Write data
    input wire logic                      dq_oe_o,     // Host drives data
    input wire logic [ASC_DATA_W-1:0]     dq_i         // Data from memory
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence wr_overlap; !pins_o.sel_n && !pins_o.wr_n; endsequence
    sequence wr_close; $rose(pins_o.wr_n) && !pins_o.sel_n; endsequence
    chk_addr_hold: assert property (wr_overlap ##1 wr_overlap |-> $stable(pins_o.addr))
        else $error("address moved in write");
    chk_addr_setup: assert property ($fell(pins_o.wr_n) |-> $stable(pins_o.addr))
        else $error("address not set up");
    chk_wdata_drive: assert property (wr_overlap |-> dq_oe_o && pins_o.oe_n)
        else $error("write without data drive");
    chk_wdata_hold: assert property (wr_close |-> dq_oe_o && $stable(dq_o))
        else $error("data not held at strobe rise");
    chk_strobe_width: assert property ($fell(pins_o.wr_n) |->
        !pins_o.wr_n[*2] ##[1:6] pins_o.wr_n) else $error("bad write strobe width");
    chk_no_clash: assert property (!pins_o.sel_n && !pins_o.oe_n |-> !dq_oe_o)
        else $error("host drives during read");
    chk_read_mode: assert property (!pins_o.oe_n |-> !pins_o.sel_n && pins_o.wr_n)
        else $error("bad read controls");
    chk_read_data: assert property (rdata_vld_o |->
        !$past(pins_o.oe_n) && rdata_o == $past(dq_i)) else $error("read data not captured");
endmodule : asc_host_checker

bind asc_host asc_host_checker u_chk (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
    .req_i(req_i), .req_vld_i(req_vld_i), .req_rdy_o(req_rdy_o), .rdata_o(rdata_o),
    .rdata_vld_o(rdata_vld_o), .wr_done_o(wr_done_o), .pins_o(pins_o), .dq_o(dq_o),
    .dq_oe_o(dq_oe_o), .dq_i(dq_i));

// ### bench/asc_sram_model.sv
// Behavioural 32K x 8 asynchronous static memory
`timescale 1ns/1ps
module asc_sram_model
    import asc_pkg::*;
(
    input  wire asc_pkg::asc_pins_t              pins_i,  // Select, strobes, address
    input  wire logic [asc_pkg::ASC_DATA_W-1:0]  din_i,   // Level on the data pins
    output logic [asc_pkg::ASC_DATA_W-1:0]       dout_o,  // Data the memory drives
    output logic                                 drive_o  // Memory drives the pins
);
    import asc_pkg::*;
    logic [ASC_DATA_W-1:0] mem [ASC_WORDS];
    logic [ASC_DATA_W-1:0] last = 8'h00;
    wire                   wr_on = !pins_i.sel_n && !pins_i.wr_n;
    assign drive_o = !pins_i.sel_n && pins_i.wr_n && !pins_i.oe_n;
    always @(negedge wr_on) mem[pins_i.addr] = din_i;
    always @* if (drive_o) last = mem[pins_i.addr];
    // Released pins show the inverse of the last value, never a stale copy
    assign dout_o = drive_o ? mem[pins_i.addr] : ~last;
endmodule : asc_sram_model

// ### bench/tb.sv
// Self-checking bench for the static memory host controller
`timescale 1ns/1ps
module tb;
    import asc_pkg::*;
    `define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fails++; \
        $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
    logic ref_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    asc_req_t req_i = '0;
    logic req_vld_i = 1'b0;
    logic req_rdy_o, rdata_vld_o, wr_done_o, dq_oe_o, mem_drv;
    logic [ASC_DATA_W-1:0] rdata_o, dq_o, dq_i, mem_dq, q;
    asc_pins_t pins_o;
    int fails = 0;
    int tests_run = 0;
    always #25 ref_clk_i = ~ref_clk_i;
    assign dq_i = dq_oe_o ? dq_o : mem_dq;
    asc_host dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .req_i(req_i),
        .req_vld_i(req_vld_i), .req_rdy_o(req_rdy_o), .rdata_o(rdata_o),
        .rdata_vld_o(rdata_vld_o), .wr_done_o(wr_done_o), .pins_o(pins_o),
        .dq_o(dq_o), .dq_oe_o(dq_oe_o), .dq_i(dq_i));
    asc_sram_model u_mem (.pins_i(pins_o), .din_i(dq_i), .dout_o(mem_dq), .drive_o(mem_drv));
    // Host must never drive while the memory drives read data
    always @(negedge ref_clk_i) begin
        if (rst_b_i && mem_drv) begin
            `CHK(dq_oe_o, 1'b0)
        end
    end
    task automatic finish_test;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test
    task automatic wait_rdy;
        for (int n = 0; req_rdy_o !== 1'b1; n++) begin
            if (n > 40) begin fails++; finish_test(); end
            @(negedge ref_clk_i);
        end
    endtask : wait_rdy
    task automatic access(input logic wr, input logic [14:0] a, input logic [7:0] d);
        @(negedge ref_clk_i);
        wait_rdy();
        req_i = '{wr: wr, addr: a, wdata: d};
        req_vld_i = 1'b1;
        @(negedge ref_clk_i);
        req_vld_i = 1'b0;
        for (int n = 0; (wr ? wr_done_o : rdata_vld_o) !== 1'b1; n++) begin
            if (n > 40) begin fails++; finish_test(); end
            @(posedge ref_clk_i);
            #1;
        end
        q = rdata_o;
    endtask : access
    task automatic t_edges;
        logic [14:0] a[3] = '{15'h0000, 15'h7FFF, 15'h2AAA};
        logic [7:0] d[3] = '{8'h5A, 8'hA5, 8'hFF};
        for (int i = 0; i < 3; i++) access(1'b1, a[i], d[i]);
        for (int i = 2; i >= 0; i--) begin
            access(1'b0, a[i], 8'h00);
            `CHK(q, d[i])
        end
        $display("edges done");
    endtask : t_edges
    task automatic t_refused;
        access(1'b1, 15'h0100, 8'h3C);
        @(negedge ref_clk_i);
        req_i = '{wr: 1'b1, addr: 15'h0100, wdata: 8'h3C};
        req_vld_i = 1'b1;
        @(negedge ref_clk_i);
        req_vld_i = 1'b0;
        repeat (2) @(negedge ref_clk_i);
        req_i = '{wr: 1'b1, addr: 15'h0100, wdata: 8'hC3};
        req_vld_i = 1'b1;
        repeat (2) @(negedge ref_clk_i);
        req_vld_i = 1'b0;
        access(1'b0, 15'h0100, 8'h00);
        `CHK(q, 8'h3C)
        $display("refused done");
    endtask : t_refused
    task automatic t_reset;
        access(1'b1, 15'h1234, 8'h96);
        @(negedge ref_clk_i);
        req_i = '{wr: 1'b1, addr: 15'h0042, wdata: 8'h0F};
        req_vld_i = 1'b1;
        repeat (2) @(negedge ref_clk_i);
        // Cut the write in the first cycle of its strobe overlap
        req_vld_i = 1'b0;
        rst_b_i = 1'b0;
        #1;
        `CHK({pins_o.sel_n, pins_o.wr_n, dq_oe_o, req_rdy_o}, 4'b1101)
        repeat (4) @(negedge ref_clk_i);
        rst_b_i = 1'b1;
        @(negedge ref_clk_i);
        `CHK({pins_o.sel_n, pins_o.oe_n, req_rdy_o}, 3'b111)
        access(1'b0, 15'h1234, 8'h00);
        `CHK(q, 8'h96)
        $display("reset done");
    endtask : t_reset
    initial begin
        repeat (4) @(negedge ref_clk_i);
        `CHK({pins_o.sel_n, pins_o.oe_n, dq_oe_o}, 3'b110)
        rst_b_i = 1'b1;
        t_edges();
        t_refused();
        t_reset();
        finish_test();
    end
endmodule : tb
